/* core/sad_top.sv */
// Purpose: system address decoder between the cpu core and all memory targets
// Assumes: request inputs synchronous to sys_clk_in and stable while req_valid_in is high
// Notes: one request is taken when ready; selects hold until access_done_in
//
// How it works
// - addresses are signed 32-bit; word index 30 bits, byte selector 2 bits
// - lowest 2 Kbytes, less the system area below user memory start, go to sram; 4 Kbytes when data cache is off
// - second 2 Kbyte sram range exists only while data cache is disabled
// - 4 Mbyte sdram window from its base goes to the shared sdram target
// - low positive region is peripheral space, reached by device accesses only
// - external region up to the top of positive space goes to external interface
// - external region is four equal banks, bank 3 holds boot rom
// - in slave mode bank 3 accesses invert address bits 21 to 19
// - rom boot fetches two bytes below top; backward jump at most 256 bytes
// - link boot waits for commands on the boot link input channel word
// - each channel dma subsystem has one state word below user memory
// - three video dma words consecutive, block move output word fixed
// - trap area: two priorities, four groups, handler and trapped structs of four words
// - area below user memory start reached only through dedicated instructions
// - each peripheral owns one aligned 4 Kbyte block from upper address bits
// - interrupt controller, demux and interrupt level blocks at fixed bases
// - four async serial, two smart card clocks, then sync serial controller
// - pwm module then five parallel io ports in consecutive blocks
// - three video dma controllers and block move dma
// - video, audio, sub-picture, tv encoder sub-blocks at 512-byte spacing
// - external interface config, diagnostic and cache config low device blocks
`timescale 1ns/1ps
module sad_top
	import sad_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	input wire logic req_valid_in,
	input wire logic [31:0] addr_in,
	input wire logic write_in,
	input wire logic device_access_in,
	input wire logic sys_instr_in,
	input wire logic access_done_in,
	input wire logic dcache_en_in,
	input wire logic slave_mode_in,
	input wire logic boot_from_link_in,
	output logic req_ready_out,
	output logic busy_out,
	output logic write_out,
	output logic [SAD_NUM_TGT-1:0] target_sel_out,
	output logic [SAD_NUM_PERIPH-1:0] periph_sel_out,
	output logic decode_err_out,
	output logic [31:0] target_addr_out,
	output logic [29:0] word_index_out,
	output logic [1:0] byte_sel_out,
	output logic [1:0] emi_bank_out,
	output logic [2:0] mpeg_sub_out,
	output logic [3:0] sys_slot_out,
	output logic trap_low_pri_out,
	output logic [1:0] trap_group_out,
	output logic trap_trapped_out,
	output logic [1:0] trap_word_out,
	output logic boot_start_out,
	output logic boot_link_wait_out,
	output logic [31:0] boot_addr_out,
	output logic [31:0] boot_jump_floor_out
);

	////////////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		sad_state_e st;
		logic ready;
		logic busy;
		logic wr;
		logic [SAD_NUM_TGT-1:0] sel;
		logic [SAD_NUM_PERIPH-1:0] psel;
		logic err;
		logic [31:0] taddr;
		logic [1:0] bank;
		sad_msub_e msub;
		sad_slot_e slot;
		logic trap_lo;
		logic [1:0] trap_grp;
		logic trap_struct;
		logic [1:0] trap_word;
		logic boot_start;
		logic link_wait;
		logic [31:0] boot_addr;
		logic [31:0] boot_floor;
	} sad_state_s;

	sad_state_s q;
	sad_state_s d;

	////////////////////////////////////////////////////////////////////////////////
	// sub-decoders

	sad_dec_if dif ();

	assign dif.addr = addr_in;
	assign dif.slave = slave_mode_in;

	sad_emi_map u_emi (
		.dif(dif.emi)
	);

	sad_periph_dec u_per (
		.dif(dif.per)
	);

	////////////////////////////////////////////////////////////////////////////////
	// range decode

	logic signed [31:0] saddr;
	logic onchip;
	logic sys_hit;
	logic sram_hit;
	logic sdram_hit;
	logic emi_hit;
	logic periph_ok;
	logic sys_ok;
	logic any_ok;
	logic [SAD_NUM_TGT-1:0] tgt_c;
	sad_slot_e slot_c;
	sad_msub_e msub_c;
	logic sram_ded;
	logic sram_ext;
	logic trap_hit;
	logic [SAD_TRAP_PRI_BIT:0] trap_off;
	logic trap_lo_c;
	logic [1:0] trap_grp_c;
	logic trap_struct_c;
	logic [1:0] trap_word_c;
	logic [SAD_NUM_PERIPH-1:0] psel_c;
	logic [1:0] bank_c;
	logic [31:0] taddr_c;

	assign saddr = $signed(addr_in);
	assign onchip = addr_in[31:30] == SAD_REG_ONCHIP;
	assign sys_hit = onchip && (saddr < $signed(SAD_USER_MEMORY_START));
	assign sram_ded = saddr < $signed(SAD_SRAM_DED_END);
	assign sram_ext = !dcache_en_in && (saddr < $signed(SAD_SRAM_EXT_END));
	assign sram_hit = onchip && !sys_hit && (sram_ded || sram_ext);
	assign sdram_hit = (addr_in >= SAD_SDRAM_BASE) && (addr_in <= SAD_SDRAM_LAST);
	assign emi_hit = (addr_in[31:30] == SAD_REG_EMI) &&
		(saddr <= $signed(SAD_HIGHEST_ADDRESS));

	function automatic logic word_is(input logic [31:0] a, input logic [31:0] w);
		return a[31:SAD_WORD_LSB] == w[31:SAD_WORD_LSB];
	endfunction

	function automatic sad_slot_e slot_of(input logic [31:0] a);
		sad_slot_e s;
		s = SAD_SLOT_RSVD;
		if (word_is(a, SAD_LINK_OUT_WORD)) begin
			s = SAD_SLOT_LINK_OUT;
		end else if (word_is(a, SAD_BOOT_SERIAL_LINK_WORD)) begin
			s = SAD_SLOT_BOOT_LINK;
		end else if (word_is(a, SAD_MDMA0_WORD)) begin
			s = SAD_SLOT_MDMA0;
		end else if (word_is(a, SAD_MDMA1_WORD)) begin
			s = SAD_SLOT_MDMA1;
		end else if (word_is(a, SAD_THIRD_VIDEO_DMA_WORD)) begin
			s = SAD_SLOT_THIRD_VIDEO_DMA;
		end else if (word_is(a, SAD_BM_OUT_WORD)) begin
			s = SAD_SLOT_BM_OUT;
		end else if ($signed(a) >= $signed(SAD_TRAP_AREA_BASE)) begin
			s = SAD_SLOT_TRAP;
		end
		return s;
	endfunction

	function automatic sad_msub_e msub_of(input logic [31:0] a);
		sad_msub_e m;
		m = SAD_MSUB_DATA;
		if (a[SAD_MSUB_MSB:SAD_MSUB_LSB] == SAD_VIDEO_BASE[SAD_MSUB_MSB:SAD_MSUB_LSB]) begin
			m = SAD_MSUB_VIDEO;
		end else if (a[SAD_MSUB_MSB:SAD_MSUB_LSB] == SAD_AUDIO_BASE[SAD_MSUB_MSB:SAD_MSUB_LSB]) begin
			m = SAD_MSUB_AUDIO;
		end else if (a[SAD_MSUB_MSB:SAD_MSUB_LSB] == SAD_SUBPIC_BASE[SAD_MSUB_MSB:SAD_MSUB_LSB]) begin
			m = SAD_MSUB_SUBPIC;
		end else if (a[SAD_MSUB_MSB:SAD_MSUB_LSB] ==
			SAD_TV_ENCODER_BASE[SAD_MSUB_MSB:SAD_MSUB_LSB]) begin
			m = SAD_MSUB_TV_ENCODER;
		end
		return m;
	endfunction

	assign slot_c = sys_hit ? slot_of(addr_in) : SAD_SLOT_NONE;
	assign msub_c = dif.phit[SAD_P_MPEG] ? msub_of(addr_in) : SAD_MSUB_NONE;
	assign periph_ok = dif.pany && device_access_in;
	assign sys_ok = sys_hit && sys_instr_in && (slot_c != SAD_SLOT_RSVD);

	always_comb begin
		tgt_c = '0;
		tgt_c[SAD_TGT_SRAM] = sram_hit;
		tgt_c[SAD_TGT_SYS] = sys_ok;
		tgt_c[SAD_TGT_SDRAM] = sdram_hit;
		tgt_c[SAD_TGT_PERIPH] = periph_ok;
		tgt_c[SAD_TGT_EMI] = emi_hit;
	end

	assign any_ok = |tgt_c;

	assign psel_c = periph_ok ? dif.phit : '0;
	assign taddr_c = emi_hit ? dif.emi_addr : addr_in;
	assign bank_c = emi_hit ? dif.bank : 2'h0;

	////////////////////////////////////////////////////////////////////////////////
	// trap area fields

	assign trap_hit = sys_ok && (slot_c == SAD_SLOT_TRAP);
	assign trap_off = addr_in[SAD_TRAP_PRI_BIT:0] -
		SAD_TRAP_AREA_BASE[SAD_TRAP_PRI_BIT:0];

	always_comb begin
		trap_lo_c = 1'b0;
		trap_grp_c = 2'h0;
		trap_struct_c = 1'b0;
		trap_word_c = 2'h0;
		if (trap_hit) begin
			trap_lo_c = trap_off[SAD_TRAP_PRI_BIT];
			trap_grp_c = trap_off[SAD_TRAP_GRP_MSB:SAD_TRAP_GRP_LSB];
			trap_struct_c = trap_off[SAD_TRAP_STRUCT_BIT];
			trap_word_c = trap_off[SAD_TRAP_WORD_MSB:SAD_TRAP_WORD_LSB];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		d = q;
		d.boot_start = 1'b0;
		case (q.st)
			SAD_ST_BOOT: begin
				d.link_wait = boot_from_link_in;
				d.boot_start = 1'b1;
				if (boot_from_link_in) begin
					d.boot_addr = SAD_BOOT_SERIAL_LINK_WORD;
					d.boot_floor = SAD_BOOT_SERIAL_LINK_WORD;
				end else begin
					d.boot_addr = SAD_ROM_BOOT_ENTRY;
					d.boot_floor = SAD_ROM_BOOT_ENTRY - SAD_BOOT_JUMP_MAX;
				end
				d.ready = 1'b1;
				d.st = SAD_ST_IDLE;
			end
			SAD_ST_IDLE: begin
				if (req_valid_in) begin
					d.st = SAD_ST_HOLD;
					d.ready = 1'b0;
					d.busy = 1'b1;
					d.wr = write_in;
					d.sel = tgt_c;
					d.psel = psel_c;
					d.err = !any_ok;
					d.taddr = taddr_c;
					d.bank = bank_c;
					d.msub = periph_ok ? msub_c : SAD_MSUB_NONE;
					d.slot = sys_ok ? slot_c : SAD_SLOT_NONE;
					d.trap_lo = trap_lo_c;
					d.trap_grp = trap_grp_c;
					d.trap_struct = trap_struct_c;
					d.trap_word = trap_word_c;
				end
			end
			SAD_ST_HOLD: begin
				if (access_done_in || q.err) begin
					d.st = SAD_ST_IDLE;
					d.ready = 1'b1;
					d.busy = 1'b0;
					d.wr = 1'b0;
					d.sel = '0;
					d.psel = '0;
					d.err = 1'b0;
					d.msub = SAD_MSUB_NONE;
					d.slot = SAD_SLOT_NONE;
					d.bank = 2'h0;
					d.trap_lo = 1'b0;
					d.trap_grp = 2'h0;
					d.trap_struct = 1'b0;
					d.trap_word = 2'h0;
				end
			end
			default: begin
				d.st = SAD_ST_IDLE;
				d.ready = 1'b1;
				d.busy = 1'b0;
				d.wr = 1'b0;
				d.sel = '0;
				d.psel = '0;
				d.err = 1'b0;
				d.msub = SAD_MSUB_NONE;
				d.slot = SAD_SLOT_NONE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			q.st <= SAD_ST_BOOT;
			q.ready <= 1'b0;
			q.busy <= 1'b0;
			q.wr <= 1'b0;
			q.sel <= '0;
			q.psel <= '0;
			q.err <= 1'b0;
			q.taddr <= '0;
			q.bank <= 2'h0;
			q.msub <= SAD_MSUB_NONE;
			q.slot <= SAD_SLOT_NONE;
			q.trap_lo <= 1'b0;
			q.trap_grp <= 2'h0;
			q.trap_struct <= 1'b0;
			q.trap_word <= 2'h0;
			q.boot_start <= 1'b0;
			q.link_wait <= 1'b0;
			q.boot_addr <= '0;
			q.boot_floor <= '0;
		end else begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	assign req_ready_out = q.ready;
	assign busy_out = q.busy;
	assign write_out = q.wr;
	assign target_sel_out = q.sel;
	assign periph_sel_out = q.psel;
	assign decode_err_out = q.err;
	assign target_addr_out = q.taddr;
	assign word_index_out = q.taddr[31:SAD_WORD_LSB];
	assign byte_sel_out = q.taddr[SAD_WORD_LSB-1:0];
	assign emi_bank_out = q.bank;
	assign mpeg_sub_out = q.msub;
	assign sys_slot_out = q.slot;
	assign trap_low_pri_out = q.trap_lo;
	assign trap_group_out = q.trap_grp;
	assign trap_trapped_out = q.trap_struct;
	assign trap_word_out = q.trap_word;
	assign boot_start_out = q.boot_start;
	assign boot_link_wait_out = q.link_wait;
	assign boot_addr_out = q.boot_addr;
	assign boot_jump_floor_out = q.boot_floor;

endmodule // sad_top

/* common/sad_pkg.sv */
// Purpose: shared constants and types for the system address decoder
// Assumes: 32-bit byte addresses, region taken from the two top bits
// Notes: peripheral table order fixes the bit order of the peripheral select
package sad_pkg;
	localparam logic [1:0] SAD_REG_PERIPH = 2'h0;
	localparam logic [1:0] SAD_REG_EMI = 2'h1;
	localparam logic [1:0] SAD_REG_ONCHIP = 2'h2;
	localparam logic [1:0] SAD_REG_SDRAM = 2'h3;
	localparam logic [31:0] SAD_LOWEST_ADDRESS = 32'h8000_0000;
	localparam logic [31:0] SAD_HIGHEST_ADDRESS = 32'h7FFF_FFFF;
	localparam logic [31:0] SAD_SRAM_DED_END = 32'h8000_0800;
	localparam logic [31:0] SAD_SRAM_EXT_END = 32'h8000_1000;
	localparam logic [31:0] SAD_USER_MEMORY_START = 32'h8000_0140;
	localparam logic [31:0] SAD_TRAP_AREA_BASE = 32'h8000_0040;
	localparam logic [31:0] SAD_LINK_OUT_WORD = 32'h8000_0000;
	localparam logic [31:0] SAD_BOOT_SERIAL_LINK_WORD = 32'h8000_0010;
	localparam logic [31:0] SAD_MDMA0_WORD = 32'h8000_0020;
	localparam logic [31:0] SAD_MDMA1_WORD = 32'h8000_0024;
	localparam logic [31:0] SAD_THIRD_VIDEO_DMA_WORD = 32'h8000_0028;
	localparam logic [31:0] SAD_BM_OUT_WORD = 32'h8000_0034;
	localparam logic [31:0] SAD_SDRAM_BASE = 32'hC000_0000;
	localparam logic [31:0] SAD_SDRAM_LAST = 32'hC03F_FFFF;
	localparam logic [31:0] SAD_ROM_BOOT_ENTRY = 32'h7FFF_FFFE;
	localparam logic [31:0] SAD_BOOT_JUMP_MAX = 32'h0000_0100;
	localparam logic [31:0] SAD_VIDEO_BASE = 32'h0000_1000;
	localparam logic [31:0] SAD_AUDIO_BASE = 32'h0000_1200;
	localparam logic [31:0] SAD_SUBPIC_BASE = 32'h0000_1400;
	localparam logic [31:0] SAD_TV_ENCODER_BASE = 32'h0000_1600;
	localparam int SAD_WORD_LSB = 2;
	localparam int SAD_BLOCK_LSB = 12;
	localparam int SAD_MSUB_MSB = 11;
	localparam int SAD_MSUB_LSB = 9;
	localparam int SAD_BANK_MSB = 29;
	localparam int SAD_BANK_LSB = 28;
	localparam logic [1:0] SAD_BANK_ROM = 2'h3;
	localparam int SAD_INV_MSB = 21;
	localparam int SAD_INV_LSB = 19;
	localparam int SAD_TRAP_PRI_BIT = 7;
	localparam int SAD_TRAP_GRP_MSB = 6;
	localparam int SAD_TRAP_GRP_LSB = 5;
	localparam int SAD_TRAP_STRUCT_BIT = 4;
	localparam int SAD_TRAP_WORD_MSB = 3;
	localparam int SAD_TRAP_WORD_LSB = 2;
	localparam int SAD_TGT_SRAM = 0;
	localparam int SAD_TGT_SYS = 1;
	localparam int SAD_TGT_SDRAM = 2;
	localparam int SAD_TGT_PERIPH = 3;
	localparam int SAD_TGT_EMI = 4;
	localparam int SAD_NUM_TGT = 5;
	localparam int SAD_NUM_PERIPH = 24;
	localparam int SAD_P_MPEG = 20;
	// intc, demux, async_serial_controller 0-3, smart card clocks 0-1, sync_serial_controller,
	// pwm, parallel_io_port 0-4, int level, video dma 0-1, third_video_dma,
	// block move dma, mpeg block, external_memory_interface cfg, diagnostic_controller, cache
	localparam logic [31:0] SAD_PERIPH_BASE [SAD_NUM_PERIPH] = '{
		32'h2000_0000, 32'h2000_2000, 32'h2000_3000, 32'h2000_4000, 32'h2000_5000,
		32'h2000_6000, 32'h2000_7000, 32'h2000_8000, 32'h2000_9000, 32'h2000_B000,
		32'h2000_C000, 32'h2000_D000, 32'h2000_E000, 32'h2000_F000, 32'h2001_0000,
		32'h2001_1000, 32'h2002_0000, 32'h2002_1000, 32'h2002_2000, 32'h2002_4000,
		32'h0000_1000, 32'h0000_2000, 32'h0000_3000, 32'h0000_4000};
	typedef enum logic [1:0] {SAD_ST_BOOT, SAD_ST_IDLE, SAD_ST_HOLD} sad_state_e;
	typedef enum logic [3:0] {SAD_SLOT_NONE, SAD_SLOT_LINK_OUT, SAD_SLOT_BOOT_LINK,
		SAD_SLOT_MDMA0, SAD_SLOT_MDMA1, SAD_SLOT_THIRD_VIDEO_DMA, SAD_SLOT_BM_OUT,
		SAD_SLOT_TRAP, SAD_SLOT_RSVD} sad_slot_e;
	typedef enum logic [2:0] {SAD_MSUB_NONE, SAD_MSUB_VIDEO, SAD_MSUB_AUDIO,
		SAD_MSUB_SUBPIC, SAD_MSUB_TV_ENCODER, SAD_MSUB_DATA} sad_msub_e;
endpackage

/* common/sad_dec_if.sv */
// Purpose: carries the request address to the sub-decoders and their results back
// Assumes: purely combinational results
// Notes: none
`timescale 1ns/1ps
interface sad_dec_if;
	import sad_pkg::*;
	logic [31:0] addr;
	logic slave;
	logic [1:0] bank;
	logic [31:0] emi_addr;
	logic [SAD_NUM_PERIPH-1:0] phit;
	logic pany;
	modport ctl (output addr, output slave, input bank, input emi_addr, input phit, input pany);
	modport emi (input addr, input slave, output bank, output emi_addr);
	modport per (input addr, output phit, output pany);
endinterface

/* core/sad_emi_map.sv */
// Purpose: bank select and slave-mode address rewrite for external accesses
// Assumes: address already known to lie in the external region
// Notes: combinational
`timescale 1ns/1ps
module sad_emi_map
	import sad_pkg::*;
(
	sad_dec_if.emi dif
);
	logic bank3;

	assign dif.bank = dif.addr[SAD_BANK_MSB:SAD_BANK_LSB];
	assign bank3 = dif.bank == SAD_BANK_ROM;

	always_comb begin
		dif.emi_addr = dif.addr;
		if (dif.slave && bank3) begin
			dif.emi_addr[SAD_INV_MSB:SAD_INV_LSB] = ~dif.addr[SAD_INV_MSB:SAD_INV_LSB];
		end
	end
endmodule // sad_emi_map

/* core/sad_periph_dec.sv */
// Purpose: one-hot match of the on-chip peripheral 4 Kbyte blocks
// Assumes: only addresses in the peripheral region can match
// Notes: bit order follows the base table
`timescale 1ns/1ps
module sad_periph_dec
	import sad_pkg::*;
(
	sad_dec_if.per dif
);
	logic in_region;

	assign in_region = dif.addr[31:30] == SAD_REG_PERIPH;

	for (genvar i = 0; i < SAD_NUM_PERIPH; i++) begin : g_blk
		localparam logic [31:0] BASE = SAD_PERIPH_BASE[i];
		assign dif.phit[i] = in_region &&
			(dif.addr[31:SAD_BLOCK_LSB] == BASE[31:SAD_BLOCK_LSB]);
	end

	assign dif.pany = |dif.phit;
endmodule // sad_periph_dec

/* verif/sad_tgt_model.sv */
// Purpose: target side model answering each selected access
// Assumes: one access at a time, select held until done
// Notes: done pulses after wait_in cycles
`timescale 1ns/1ps
module sad_tgt_model
	import sad_pkg::*;
(
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic [SAD_NUM_TGT-1:0] sel_in,
	input wire logic [3:0] wait_in,
	output logic done_out
);
	logic [3:0] cnt_q;
	always_ff @(posedge clk_in) begin
		if (!rstn_in || sel_in == '0 || done_out) begin
			cnt_q <= 4'h0;
			done_out <= 1'h0;
		end else if (cnt_q >= wait_in) begin
			done_out <= 1'h1;
		end else begin
			cnt_q <= cnt_q + 4'h1;
		end
	end
endmodule // sad_tgt_model

/* verif/sad_top_asserts.sv */
// Purpose: port-level checks of the address decoder
// Assumes: synchronous active-low reset
// Notes: bound to sad_top
`timescale 1ns/1ps
module sad_top_asserts
	import sad_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	input wire logic req_valid_in,
	input wire logic [31:0] addr_in,
	input wire logic access_done_in,
	input wire logic dcache_en_in,
	input wire logic slave_mode_in,
	input wire logic req_ready_out,
	input wire logic busy_out,
	input wire logic [SAD_NUM_TGT-1:0] target_sel_out,
	input wire logic decode_err_out,
	input wire logic [31:0] target_addr_out,
	input wire logic [29:0] word_index_out,
	input wire logic [1:0] byte_sel_out,
	input wire logic [1:0] emi_bank_out
);
	logic tk;
	logic sl_q;
	logic [31:0] ta_q;
	assign tk = req_ready_out && req_valid_in;
	always_ff @(posedge sys_clk_in) begin
		if (tk) begin
			ta_q <= addr_in;
			sl_q <= slave_mode_in;
		end
	end
	////////////////////////////////////////////////////////////////
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rstn_in);
	a_sel_one_hot: assert property ($onehot0(target_sel_out))
		else $error("select not one-hot");
	a_err_no_sel: assert property (decode_err_out |-> target_sel_out == '0)
		else $error("select with error");
	a_err_one_cycle: assert property (decode_err_out
		|=> !decode_err_out && !busy_out && req_ready_out)
		else $error("error not a single pulse");
	a_take_busy: assert property (tk |=> busy_out && !req_ready_out)
		else $error("take not busy");
	a_sel_hold: assert property (busy_out && !access_done_in && target_sel_out != '0
		|=> $stable(target_sel_out) && $stable(target_addr_out))
		else $error("select moved in access");
	a_word_split: assert property ({word_index_out, byte_sel_out} == target_addr_out)
		else $error("word split wrong");
	a_sram_upper: assert property (tk && addr_in[31:11] == 21'h10_0001
		|=> (target_sel_out == 5'h01) == !$past(dcache_en_in))
		else $error("upper sram decode wrong");
	a_sdram_window: assert property (tk && addr_in[31:22] == 10'h300
		|=> target_sel_out == 5'h04)
		else $error("sdram decode wrong");
	a_emi_bank: assert property (tk && addr_in[31:30] == 2'h1
		|=> target_sel_out == 5'h10 && emi_bank_out == ta_q[29:28])
		else $error("external bank wrong");
	a_bank3_invert: assert property (tk && addr_in[31:30] == 2'h1 |=> target_addr_out ==
		(ta_q ^ ((sl_q && ta_q[29:28] == 2'h3) ? 32'h0038_0000 : 32'h0)))
		else $error("external address wrong");
endmodule // sad_top_asserts
bind sad_top sad_top_asserts i_sad_top_asserts (
	.sys_clk_in(sys_clk_in),
	.rstn_in(rstn_in),
	.req_valid_in(req_valid_in),
	.addr_in(addr_in),
	.access_done_in(access_done_in),
	.dcache_en_in(dcache_en_in),
	.slave_mode_in(slave_mode_in),
	.req_ready_out(req_ready_out),
	.busy_out(busy_out),
	.target_sel_out(target_sel_out),
	.decode_err_out(decode_err_out),
	.target_addr_out(target_addr_out),
	.word_index_out(word_index_out),
	.byte_sel_out(byte_sel_out),
	.emi_bank_out(emi_bank_out)
);

/* verif/sad_top_tb.sv */
// Purpose: self-checking bench for the address decoder
// Assumes: target model answers after tw cycles
// Notes: inputs change on the falling edge
`timescale 1ns/1ps
module sad_top_tb;
	import sad_pkg::*;
	logic clk = 0, rstn = 0, vld = 0, wr = 0, dev = 0, sys = 0, dc = 0, sl = 0, lnk = 0;
	logic [31:0] adr = '0;
	logic [3:0] tw = 4'h1;
	logic done, rdy, bsy, wro, err, bst, lwt, tlp, ttr;
	logic [4:0] sel;
	logic [23:0] per;
	logic [31:0] ta, ba, bf;
	logic [29:0] wi;
	logic [1:0] bs, bk, tg, twd;
	logic [2:0] ms;
	logic [3:0] slot;
	int mismatches = 0, checks_done = 0;
	always #50 clk = ~clk;
	sad_top i_sad_top (.sys_clk_in(clk), .rstn_in(rstn), .req_valid_in(vld), .addr_in(adr),
		.write_in(wr), .device_access_in(dev), .sys_instr_in(sys), .access_done_in(done),
		.dcache_en_in(dc), .slave_mode_in(sl), .boot_from_link_in(lnk), .req_ready_out(rdy),
		.busy_out(bsy), .write_out(wro), .target_sel_out(sel), .periph_sel_out(per),
		.decode_err_out(err), .target_addr_out(ta), .word_index_out(wi), .byte_sel_out(bs),
		.emi_bank_out(bk), .mpeg_sub_out(ms), .sys_slot_out(slot), .trap_low_pri_out(tlp),
		.trap_group_out(tg), .trap_trapped_out(ttr), .trap_word_out(twd),
		.boot_start_out(bst), .boot_link_wait_out(lwt), .boot_addr_out(ba),
		.boot_jump_floor_out(bf));
	sad_tgt_model i_sad_tgt_model (.clk_in(clk), .rstn_in(rstn), .sel_in(sel), .wait_in(tw),
		.done_out(done));
	////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			mismatches++;
			$display("BAD %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic stop_test;
		if (mismatches == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic rst(input logic l);
		rstn = 0;
		lnk = l;
		repeat (3) @(negedge clk);
		rstn = 1;
		@(negedge clk);
	endtask
	task automatic go(input logic [31:0] a, input logic d, input logic s, input logic [5:0] e);
		int n;
		n = 0;
		while (rdy !== 1'h1) begin
			@(negedge clk);
			n++;
			if (n > 50) begin
				mismatches++;
				stop_test();
			end
		end
		adr = a;
		dev = d;
		sys = s;
		vld = 1;
		@(negedge clk);
		vld = 0;
		chk("sel", {err, sel}, e);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_boot;
		rst(0);
		chk("bst", bst, 1'h1);
		chk("rom", ba, 32'h7FFF_FFFE);
		chk("flr", bf, 32'h7FFF_FEFE);
		chk("lwt", lwt, 1'h0);
		@(negedge clk);
		chk("bst", bst, 1'h0);
		rst(1);
		chk("lnk", ba, 32'h8000_0010);
		chk("lfl", bf, 32'h8000_0010);
		chk("lwt", lwt, 1'h1);
		rst(0);
	endtask
	task automatic t_onchip;
		wr = 1;
		go(32'h8000_0803, 1'h0, 1'h0, 6'h01);
		chk("wr", {wro, bs}, 3'h7);
		chk("wi", wi, 30'h2000_0200);
		wr = 0;
		go(32'h8000_0200, 1'h0, 1'h0, 6'h01);
		chk("rd", {wro, bs}, 3'h0);
		go(32'h8000_1000, 1'h0, 1'h0, 6'h20);
		dc = 1;
		go(32'h8000_0800, 1'h0, 1'h0, 6'h20);
		dc = 0;
	endtask
	task automatic t_sdram;
		go(32'hC000_0000, 1'h0, 1'h0, 6'h04);
		go(32'hC03F_FFFC, 1'h0, 1'h0, 6'h04);
		go(32'hC040_0000, 1'h0, 1'h0, 6'h20);
	endtask
	task automatic t_emi;
		logic [31:0] a;
		sl = 1;
		for (int b = 0; b < 4; b++) begin
			a = 32'h4008_0000 + (b << 28);
			go(a, 1'h0, 1'h0, 6'h10);
			chk("bank", bk, b[1:0]);
			chk("emia", ta, b == 3 ? a ^ 32'h0038_0000 : a);
		end
		sl = 0;
		go(32'h7FF8_0000, 1'h0, 1'h0, 6'h10);
		chk("nsl", ta, 32'h7FF8_0000);
	endtask
	task automatic t_periph;
		for (int i = 0; i < SAD_NUM_PERIPH; i++) begin
			go(SAD_PERIPH_BASE[i] + 32'hFFC, 1'h1, 1'h0, 6'h08);
			chk("per", per, 32'h1 << i);
		end
		for (int k = 0; k < 4; k++) begin
			go(32'h1000 + k * 32'h200, 1'h1, 1'h0, 6'h08);
			chk("msub", ms, k + 1);
		end
		go(32'h2000_1000, 1'h1, 1'h0, 6'h20);
		go(32'h2000_A000, 1'h1, 1'h0, 6'h20);
		go(32'h2002_3000, 1'h1, 1'h0, 6'h20);
		go(32'h0000_0000, 1'h1, 1'h0, 6'h20);
		go(32'h2000_2000, 1'h0, 1'h0, 6'h20);
	endtask
	task automatic t_sys;
		logic [31:0] sa [6] = '{32'h8000_0000, 32'h8000_0010, 32'h8000_0020, 32'h8000_0024,
			32'h8000_0028, 32'h8000_0034};
		for (int i = 0; i < 6; i++) begin
			go(sa[i], 1'h0, 1'h1, 6'h02);
			chk("slot", slot, i + 1);
		end
		go(32'h8000_00D8, 1'h0, 1'h1, 6'h02);
		chk("trap", {slot, tlp, tg, ttr, twd}, 10'h1E6);
		go(32'h8000_00A4, 1'h0, 1'h1, 6'h02);
		chk("trap", {slot, tlp, tg, ttr, twd}, 10'h1D9);
		go(32'h8000_0010, 1'h0, 1'h0, 6'h20);
		go(32'h8000_0038, 1'h0, 1'h1, 6'h20);
		go(32'h8000_0140, 1'h0, 1'h0, 6'h01);
	endtask
	task automatic t_hold;
		tw = 4'h6;
		go(32'h8000_0300, 1'h0, 1'h0, 6'h01);
		adr = 32'h4000_0000;
		vld = 1;
		repeat (3) @(negedge clk);
		chk("hold", {bsy, sel}, 6'h21);
		chk("hta", ta, 32'h8000_0300);
		vld = 0;
		tw = 4'h0;
		go(32'hC000_0100, 1'h0, 1'h0, 6'h04);
		go(32'h8000_0204, 1'h0, 1'h0, 6'h01);
	endtask
	initial begin
		t_boot();
		t_onchip();
		t_sdram();
		t_emi();
		t_periph();
		t_sys();
		t_hold();
		stop_test();
	end
endmodule // sad_top_tb
